//--- shared/hbc_pkg.sv
// Purpose: shared constants for the headset bias and capture control bank
// Assumes: 200 MHz system clock, APB word addressing of byte-indexed registers
// Notes: byte address of a register is four times its index
package hbc_pkg;
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned NS_PER_MS = 1000000;
   localparam int unsigned RAMP_MS_0 = 10;
   localparam int unsigned RAMP_MS_1 = 40;
   localparam int unsigned RAMP_MS_2 = 90;
   localparam int unsigned RAMP_MS_3 = 170;
   localparam int unsigned RAMP_CNT_W = 26;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned SAMPLE_W = 24;

   localparam logic [15:0] IDX_MIC_BIAS = 16'h1c03;
   localparam logic [15:0] IDX_BIAS_POWER = 16'h1c04;
   localparam logic [15:0] IDX_BIAS_STATUS = 16'h1c05;
   localparam logic [15:0] IDX_CAP_CTRL = 16'h1d01;
   localparam logic [15:0] IDX_CAP_SOFT_RAMP = 16'h1d02;
   localparam logic [15:0] IDX_CAP_GAIN = 16'h1d03;

   localparam logic [7:0] RST_MIC_BIAS = 8'hc2;
   localparam logic [7:0] RST_BIAS_POWER = 8'h00;
   localparam logic [7:0] RST_CAP_CTRL = 8'h00;
   localparam logic [7:0] RST_CAP_SOFT_RAMP = 8'h02;
   localparam logic [7:0] RST_CAP_GAIN = 8'h00;

   localparam logic [7:0] WMASK_MIC_BIAS = 8'h93;
   localparam logic [7:0] WMASK_BIAS_POWER = 8'h01;
   localparam logic [7:0] WMASK_CAP_CTRL = 8'h35;
   localparam logic [7:0] WMASK_CAP_SOFT_RAMP = 8'h04;
   localparam logic [7:0] WMASK_CAP_GAIN = 8'hff;
   localparam logic [7:0] RAMP_FIELD_MASK = 8'h03;

   localparam int unsigned BIT_NO_CAP = 7;
   localparam int unsigned BIT_PULLDOWN = 4;
   localparam int unsigned BIT_POWER = 0;
   localparam int unsigned BIT_NOTCH_OFF = 5;
   localparam int unsigned BIT_WEAK_CM = 4;
   localparam int unsigned BIT_POL_FLIP = 2;
   localparam int unsigned BIT_BOOST = 0;
   localparam int unsigned BIT_GRADUAL = 2;
   localparam int unsigned BIT_ST_HEADSET = 0;
   localparam int unsigned BIT_ST_SHORT = 1;
   localparam int unsigned BIT_ST_BUSY = 2;

   localparam logic [7:0] GAIN_SAT_CODE = 8'h0c;
   localparam logic signed [7:0] GAIN_MAX_DB = 8'sh0c;
   localparam logic [7:0] MUTE_LO = 8'h80;
   localparam logic [7:0] MUTE_HI = 8'h9f;
   localparam logic [27:0] BOOST_FACTOR = 28'h000000a;

   typedef enum logic [1:0] {RS_OFF, RS_RAMP, RS_ON} hbc_ramp_state_t;

   function automatic logic [ADDR_W-1:0] addr_of(input logic [15:0] idx);
      addr_of = {idx[13:0], 2'b00};
   endfunction : addr_of
endpackage : hbc_pkg

//--- shared/hbc_ramp_if.sv
// Purpose: carries bias power and ramp rate to the ramp timer and its state back
// Assumes: single clock domain
// Notes: ctl side is the register bank, tmr side is the timer
`timescale 1ns/100ps
`default_nettype none
interface hbc_ramp_if;
   logic power_on;
   logic [1:0] rate;
   logic busy;
   logic settled;
   modport ctl (output power_on, output rate, input busy, input settled);
   modport tmr (input power_on, input rate, output busy, output settled);
endinterface : hbc_ramp_if
`default_nettype wire

//--- src/hbc_ramp_timer.sv
// Purpose: times the bias output ramp after each power level change
// Assumes: ramp counts given in system clock cycles
// Notes: rate is latched when the ramp starts
`timescale 1ns/100ps
`default_nettype none
module hbc_ramp_timer
   import hbc_pkg::*;
#(
   parameter int unsigned CYC_0 = 1,
   parameter int unsigned CYC_1 = 1,
   parameter int unsigned CYC_2 = 1,
   parameter int unsigned CYC_3 = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   hbc_ramp_if.tmr rif
);
   hbc_ramp_state_t state_ff, nxt_state;
   logic [RAMP_CNT_W-1:0] cnt_ff, nxt_cnt, limit_ff, nxt_limit;
   logic pwr_ff;
   logic pwr_change;

   function automatic logic [RAMP_CNT_W-1:0] limit_of(input logic [1:0] rate);
      unique case (rate)
         2'b00: limit_of = RAMP_CNT_W'(CYC_0);
         2'b01: limit_of = RAMP_CNT_W'(CYC_1);
         2'b10: limit_of = RAMP_CNT_W'(CYC_2);
         2'b11: limit_of = RAMP_CNT_W'(CYC_3);
      endcase
   endfunction : limit_of

   // ramps run both ways, so a fall restarts the delay as well
   assign pwr_change = rif.power_on != pwr_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_limit = limit_ff;
      if (pwr_change) begin
         nxt_state = RS_RAMP;
         nxt_cnt = '0;
         nxt_limit = limit_of(rif.rate);
      end else begin
         unique case (state_ff)
            RS_RAMP: begin
               if (cnt_ff >= limit_ff) begin
                  nxt_state = pwr_ff ? RS_ON : RS_OFF;
               end else begin
                  nxt_cnt = cnt_ff + 1'b1;
               end
            end
            RS_ON, RS_OFF: begin
               nxt_state = state_ff;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_ff <= RS_OFF;
         cnt_ff <= '0;
         limit_ff <= '0;
         pwr_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         limit_ff <= nxt_limit;
         pwr_ff <= rif.power_on;
      end
   end

   assign rif.busy = (state_ff == RS_RAMP) || pwr_change;
   assign rif.settled = (state_ff == RS_ON) && !pwr_change;
endmodule : hbc_ramp_timer
`default_nettype wire

//--- src/hbc_regs_top.sv
// Purpose: APB register bank for headset bias and capture path controls
// Assumes: zero-wait APB slave, capture samples synchronous to I_SYS_CLK
// Notes: gain leaves as dB for the downstream multiplier; mute and flips act here
// Functional notes
// - bias bit 7 no-capacitor flag, resets 1
// - bias bit 4 connects pull-down resistor
// - ramp rate bits 1:0, reset 10
// - ramp rate locked until ramp delay elapses
// - detect status valid only after ramp delay
// - capture bit 5 turns notch filter off
// - capture bit 4 forces weak common mode
// - capture bit 2 inverts sample polarity
// - capture bit 0 adds 20 dB boost
// - soft ramp bit 2 steps gain gradually
// - gain code 0 dB reset, saturates +12
// - codes 80 to 9f mute capture
`timescale 1ns/100ps
`default_nettype none
module hbc_regs_top
   import hbc_pkg::*;
#(
   parameter int unsigned RAMP_CYC_0 = RAMP_MS_0 * NS_PER_MS / CLK_PERIOD_NS,
   parameter int unsigned RAMP_CYC_1 = RAMP_MS_1 * NS_PER_MS / CLK_PERIOD_NS,
   parameter int unsigned RAMP_CYC_2 = RAMP_MS_2 * NS_PER_MS / CLK_PERIOD_NS,
   parameter int unsigned RAMP_CYC_3 = RAMP_MS_3 * NS_PER_MS / CLK_PERIOD_NS
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic O_MIC_BIAS_NO_CAP_FLAG,
   output logic O_MIC_BIAS_PULLDOWN_ON,
   output logic [1:0] O_MIC_BIAS_RAMP_RATE,
   output logic O_MIC_BIAS_POWER_LEVEL,
   input wire logic I_HEADSET_TYPE_RAW,
   input wire logic I_SHORT_RAW,
   output logic O_HEADSET_TYPE_VALID,
   output logic O_SHORT_VALID,
   output logic O_CAPTURE_NOTCH_OFF,
   output logic O_CAPTURE_WEAK_CM_FORCE,
   input wire logic I_SOFT_RAMP_STEP,
   input wire logic I_CAP_VALID,
   input wire logic [SAMPLE_W-1:0] I_CAP_SAMPLE,
   output logic O_CAP_VALID,
   output logic [SAMPLE_W-1:0] O_CAP_SAMPLE,
   output logic signed [7:0] O_CAP_GAIN_DB,
   output logic O_CAP_MUTE
);
   logic [7:0] mic_bias_ff, bias_power_ff, cap_ctrl_ff, cap_soft_ramp_ff, cap_gain_ff;
   logic [7:0] nxt_mic_bias;
   logic [31:0] prdata_ff;
   logic signed [7:0] gain_db_ff, nxt_gain_db;
   logic mute_ff;
   logic cap_valid_ff;
   logic [SAMPLE_W-1:0] cap_sample_ff;

   hbc_ramp_if rif ();

   function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] wd,
                                         input logic [7:0] mask);
      wmerge = (old & ~mask) | (wd & mask);
   endfunction : wmerge

   function automatic logic [SAMPLE_W-1:0] sat_sample(input logic signed [27:0] v);
      logic signed [27:0] hi;
      logic signed [27:0] lo;
      hi = 28'sh07fffff;
      lo = -28'sh0800000;
      if (v > hi) sat_sample = hi[SAMPLE_W-1:0];
      else if (v < lo) sat_sample = lo[SAMPLE_W-1:0];
      else sat_sample = v[SAMPLE_W-1:0];
   endfunction : sat_sample

   // bus decode
   wire acc_phase = I_PSEL && I_PENABLE;
   wire setup_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
   wire hit_bias = I_PADDR == addr_of(IDX_MIC_BIAS);
   wire hit_power = I_PADDR == addr_of(IDX_BIAS_POWER);
   wire hit_status = I_PADDR == addr_of(IDX_BIAS_STATUS);
   wire hit_ctrl = I_PADDR == addr_of(IDX_CAP_CTRL);
   wire hit_ramp = I_PADDR == addr_of(IDX_CAP_SOFT_RAMP);
   wire hit_gain = I_PADDR == addr_of(IDX_CAP_GAIN);
   wire hit_any = hit_bias | hit_power | hit_status | hit_ctrl | hit_ramp | hit_gain;
   wire wr_en = acc_phase && I_PWRITE;
   wire [7:0] wd = I_PWDATA[7:0];

   // ramp field writes are dropped while the bias is still ramping
   wire [7:0] bias_wmask = rif.busy ? (WMASK_MIC_BIAS & ~RAMP_FIELD_MASK)
                                    : WMASK_MIC_BIAS;
   assign nxt_mic_bias = wmerge(mic_bias_ff, wd, bias_wmask);

   wire [7:0] status_w = 8'((rif.busy ? 8'h01 : 8'h00) << BIT_ST_BUSY)
                       | 8'((O_SHORT_VALID ? 8'h01 : 8'h00) << BIT_ST_SHORT)
                       | 8'((O_HEADSET_TYPE_VALID ? 8'h01 : 8'h00) << BIT_ST_HEADSET);
   wire [7:0] rd_byte = hit_bias ? mic_bias_ff
                      : hit_power ? bias_power_ff
                      : hit_status ? status_w
                      : hit_ctrl ? cap_ctrl_ff
                      : hit_ramp ? cap_soft_ramp_ff
                      : hit_gain ? cap_gain_ff : 8'h00;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         mic_bias_ff <= RST_MIC_BIAS;
         bias_power_ff <= RST_BIAS_POWER;
         cap_ctrl_ff <= RST_CAP_CTRL;
         cap_soft_ramp_ff <= RST_CAP_SOFT_RAMP;
         cap_gain_ff <= RST_CAP_GAIN;
      end else if (wr_en) begin
         if (hit_bias) mic_bias_ff <= nxt_mic_bias;
         if (hit_power) bias_power_ff <= wmerge(bias_power_ff, wd, WMASK_BIAS_POWER);
         if (hit_ctrl) cap_ctrl_ff <= wmerge(cap_ctrl_ff, wd, WMASK_CAP_CTRL);
         if (hit_ramp) cap_soft_ramp_ff <= wmerge(cap_soft_ramp_ff, wd, WMASK_CAP_SOFT_RAMP);
         if (hit_gain) cap_gain_ff <= wmerge(cap_gain_ff, wd, WMASK_CAP_GAIN);
      end
   end

   // read data is captured in the setup cycle so it leaves a flip-flop
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         prdata_ff <= 32'h00000000;
      end else if (setup_rd) begin
         prdata_ff <= {24'h000000, rd_byte};
      end
   end

   assign O_PRDATA = prdata_ff;
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = acc_phase && !hit_any;

   assign rif.power_on = bias_power_ff[BIT_POWER];
   assign rif.rate = mic_bias_ff[1:0];

   hbc_ramp_timer #(
      .CYC_0(RAMP_CYC_0),
      .CYC_1(RAMP_CYC_1),
      .CYC_2(RAMP_CYC_2),
      .CYC_3(RAMP_CYC_3)
   ) u_ramp_timer (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .rif(rif.tmr)
   );

   assign O_MIC_BIAS_NO_CAP_FLAG = mic_bias_ff[BIT_NO_CAP];
   assign O_MIC_BIAS_PULLDOWN_ON = mic_bias_ff[BIT_PULLDOWN];
   assign O_MIC_BIAS_RAMP_RATE = mic_bias_ff[1:0];
   assign O_MIC_BIAS_POWER_LEVEL = bias_power_ff[BIT_POWER];
   assign O_HEADSET_TYPE_VALID = I_HEADSET_TYPE_RAW && rif.settled;
   assign O_SHORT_VALID = I_SHORT_RAW && rif.settled;
   assign O_CAPTURE_NOTCH_OFF = cap_ctrl_ff[BIT_NOTCH_OFF];
   assign O_CAPTURE_WEAK_CM_FORCE = cap_ctrl_ff[BIT_WEAK_CM];

   // gain decode
   wire pol_flip = cap_ctrl_ff[BIT_POL_FLIP];
   wire boost_on = cap_ctrl_ff[BIT_BOOST];
   wire gradual_on = cap_soft_ramp_ff[BIT_GRADUAL];
   wire code_mute = (cap_gain_ff >= MUTE_LO) && (cap_gain_ff <= MUTE_HI);
   wire code_sat = !cap_gain_ff[7] && (cap_gain_ff >= GAIN_SAT_CODE);
   // codes above the mute band read as two's complement attenuation
   wire signed [7:0] target_db = code_sat ? GAIN_MAX_DB
                                          : $signed(cap_gain_ff);
   wire step_up = gain_db_ff < target_db;

   always_comb begin
      nxt_gain_db = gain_db_ff;
      if (!gradual_on) begin
         nxt_gain_db = target_db;
      end else if (I_SOFT_RAMP_STEP && (gain_db_ff != target_db)) begin
         nxt_gain_db = step_up ? gain_db_ff + 8'sh01 : gain_db_ff - 8'sh01;
      end
   end

   // sample path: flip, then boost, then mute
   wire signed [27:0] smp_x = 28'(signed'(I_CAP_SAMPLE));
   wire [SAMPLE_W-1:0] smp_flip = pol_flip ? sat_sample(-smp_x) : I_CAP_SAMPLE;
   wire signed [27:0] flip_x = 28'(signed'(smp_flip));
   wire [SAMPLE_W-1:0] smp_boost = boost_on ? sat_sample(28'(flip_x * signed'(BOOST_FACTOR)))
                                            : smp_flip;
   wire [SAMPLE_W-1:0] smp_out = code_mute ? '0 : smp_boost;

   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         gain_db_ff <= 8'sh00;
         mute_ff <= 1'b0;
         cap_valid_ff <= 1'b0;
         cap_sample_ff <= '0;
      end else begin
         gain_db_ff <= nxt_gain_db;
         mute_ff <= code_mute;
         cap_valid_ff <= I_CAP_VALID;
         if (I_CAP_VALID) cap_sample_ff <= smp_out;
      end
   end

   assign O_CAP_VALID = cap_valid_ff;
   assign O_CAP_SAMPLE = cap_sample_ff;
   assign O_CAP_GAIN_DB = gain_db_ff;
   assign O_CAP_MUTE = mute_ff;

   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_RST);

   no_cap_reset_a: assert property ($fell(I_RST) |-> O_MIC_BIAS_NO_CAP_FLAG)
      else $error("no-capacitor flag not set after reset");

   pulldown_write_a: assert property (wr_en && hit_bias |=>
      O_MIC_BIAS_PULLDOWN_ON == $past(I_PWDATA[4]))
      else $error("pull-down bit did not follow write");

   ramp_reset_a: assert property ($fell(I_RST) |-> O_MIC_BIAS_RAMP_RATE == 2'b10)
      else $error("ramp rate reset value wrong");

   ramp_lock_a: assert property (wr_en && hit_bias && rif.busy |=>
      $stable(O_MIC_BIAS_RAMP_RATE))
      else $error("ramp rate changed during ramp");

   status_gate_a: assert property (O_HEADSET_TYPE_VALID || O_SHORT_VALID |->
      rif.settled && O_MIC_BIAS_POWER_LEVEL)
      else $error("detect status valid before ramp done");

   notch_write_a: assert property (wr_en && hit_ctrl |=>
      O_CAPTURE_NOTCH_OFF == $past(I_PWDATA[5]) && O_CAPTURE_WEAK_CM_FORCE == $past(I_PWDATA[4]))
      else $error("notch or weak bias bit did not follow write");

   polarity_a: assert property (I_CAP_VALID && pol_flip && !boost_on && !code_mute
      && I_CAP_SAMPLE == 24'h000005 |=> O_CAP_SAMPLE == 24'hfffffb)
      else $error("polarity flip wrong");

   boost_a: assert property (I_CAP_VALID && boost_on && !pol_flip && !code_mute
      && I_CAP_SAMPLE == 24'h000003 |=> O_CAP_SAMPLE == 24'h00001e)
      else $error("boost gain wrong");

   gradual_hold_a: assert property (gradual_on && !I_SOFT_RAMP_STEP |=>
      $stable(O_CAP_GAIN_DB))
      else $error("gain moved without a ramp step");

   gain_sat_a: assert property (!gradual_on && code_sat |=> O_CAP_GAIN_DB == 8'sh0c)
      else $error("gain did not saturate at 12 dB");

   mute_a: assert property (I_CAP_VALID && code_mute |=>
      O_CAP_SAMPLE == '0 && O_CAP_MUTE)
      else $error("mute band did not silence samples");

   atten_a: assert property (!gradual_on && cap_gain_ff == 8'hf6 |=>
      O_CAP_GAIN_DB == -8'sd10)
      else $error("attenuation code decoded wrong");
endmodule : hbc_regs_top
`default_nettype wire

//--- dv/hbc_regs_top_tb.sv
// Purpose: self-checking bench for the headset bias and capture register bank
// Assumes: zero-wait APB slave, ramp counts shortened by parameter
// Notes: expectations come from the register map and gain table, never from the design
`timescale 1ns/100ps
`default_nettype none
module hbc_regs_top_tb
   import hbc_pkg::*;
;
   localparam int unsigned CYC0 = 20;
   localparam logic [15:0] A_BIAS = 16'h700c;
   localparam logic [15:0] A_PWR = 16'h7010;
   localparam logic [15:0] A_STAT = 16'h7014;
   localparam logic [15:0] A_CTRL = 16'h7404;
   localparam logic [15:0] A_SOFT = 16'h7408;
   localparam logic [15:0] A_GAIN = 16'h740c;
   localparam logic [15:0] A_NONE = 16'h7000;
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic no_cap, pull_on, pwr_on, hs_raw, sh_raw, hs_valid, sh_valid;
   logic [1:0] rate;
   logic notch_off, weak_cm, step_p, cvalid, ocvalid, mute;
   logic [23:0] csample, osample;
   logic signed [7:0] gain_db;
   logic [31:0] r;
   logic e;
   int fails, tests_run, n;
   logic [7:0] g_code [10] = '{8'h00, 8'h0b, 8'h0c, 8'h7f, 8'hff, 8'ha0, 8'hfe, 8'hf6,
                               8'h80, 8'h9f};
   logic [7:0] g_db [10] = '{8'h00, 8'h0b, 8'h0c, 8'h0c, 8'hff, 8'ha0, 8'hfe, 8'hf6,
                             8'h00, 8'h00};

   hbc_regs_top #(.RAMP_CYC_0(CYC0), .RAMP_CYC_1(40), .RAMP_CYC_2(60), .RAMP_CYC_3(80)) i_dut (
      .I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_MIC_BIAS_NO_CAP_FLAG(no_cap), .O_MIC_BIAS_PULLDOWN_ON(pull_on),
      .O_MIC_BIAS_RAMP_RATE(rate), .O_MIC_BIAS_POWER_LEVEL(pwr_on),
      .I_HEADSET_TYPE_RAW(hs_raw), .I_SHORT_RAW(sh_raw), .O_HEADSET_TYPE_VALID(hs_valid),
      .O_SHORT_VALID(sh_valid), .O_CAPTURE_NOTCH_OFF(notch_off),
      .O_CAPTURE_WEAK_CM_FORCE(weak_cm), .I_SOFT_RAMP_STEP(step_p), .I_CAP_VALID(cvalid),
      .I_CAP_SAMPLE(csample), .O_CAP_VALID(ocvalid), .O_CAP_SAMPLE(osample),
      .O_CAP_GAIN_DB(gain_db), .O_CAP_MUTE(mute));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one APB transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [31:0] rd, output logic err);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         fails++;
         test_done();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [31:0] x;
      logic y;
      apb(1'b1, a, d, x, y);
   endtask : wr

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00, r, e);
      check(r, {24'h000000, exp});
   endtask : rd_chk

   task automatic cap(input logic [23:0] s, input logic [23:0] exp);
      @(posedge clk);
      cvalid <= 1'b1;
      csample <= s;
      @(posedge clk);
      cvalid <= 1'b0;
      #1;
      check({31'h0, ocvalid}, 32'h1);
      check({8'h00, osample}, {8'h00, exp});
   endtask : cap

   task automatic settle(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask : settle

   task automatic step();
      @(posedge clk);
      step_p <= 1'b1;
      @(posedge clk);
      step_p <= 1'b0;
      settle(1);
   endtask : step

   task automatic end_test(input string nm);
      $display("test %s finished", nm);
   endtask : end_test

   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, hs_raw, sh_raw, step_p, cvalid} = 7'h00;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      csample = 24'h000000;
      fails = 0;
      tests_run = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(A_BIAS, 8'hc2);
      rd_chk(A_CTRL, 8'h00);
      rd_chk(A_SOFT, 8'h02);
      rd_chk(A_GAIN, 8'h00);
      end_test("reset values");
      wr(A_BIAS, 8'hff);
      rd_chk(A_BIAS, 8'hd3);
      check({30'h0, no_cap, pull_on}, 32'h3);
      wr(A_BIAS, 8'h00);
      rd_chk(A_BIAS, 8'h40);
      check({30'h0, no_cap, pull_on}, 32'h0);
      for (int c = 0; c < 4; c++) begin
         wr(A_BIAS, 8'h80 | 8'(c));
         rd_chk(A_BIAS, 8'hc0 | 8'(c));
         check({30'h0, rate}, 32'(c));
      end
      end_test("bias fields");
      wr(A_BIAS, 8'h80);
      hs_raw <= 1'b1;
      sh_raw <= 1'b1;
      wr(A_PWR, 8'h01);
      rd_chk(A_STAT, 8'h04);
      check({31'h0, pwr_on}, 32'h1);
      // a rate change in mid-ramp must be dropped while the pull-down bit still lands
      wr(A_BIAS, 8'h93);
      rd_chk(A_BIAS, 8'hd0);
      check({30'h0, hs_valid, sh_valid}, 32'h0);
      n = 0;
      while (hs_valid !== 1'b1 && n < 10 * CYC0) begin
         @(posedge clk);
         n++;
      end
      check({30'h0, hs_valid, sh_valid}, 32'h3);
      rd_chk(A_STAT, 8'h03);
      wr(A_BIAS, 8'h93);
      rd_chk(A_BIAS, 8'hd3);
      // power fall ramps too, timed by the slowest rate now in the field
      wr(A_PWR, 8'h00);
      settle(60);
      rd_chk(A_STAT, 8'h04);
      check({31'h0, pwr_on}, 32'h0);
      settle(40);
      rd_chk(A_STAT, 8'h00);
      end_test("ramp lock");
      wr(A_CTRL, 8'hff);
      rd_chk(A_CTRL, 8'h35);
      check({30'h0, notch_off, weak_cm}, 32'h3);
      wr(A_CTRL, 8'h00);
      settle(1);
      check({30'h0, notch_off, weak_cm}, 32'h0);
      cap(24'h123456, 24'h123456);
      wr(A_CTRL, 8'h04);
      cap(24'h000100, 24'hffff00);
      cap(24'h000005, 24'hfffffb);
      wr(A_CTRL, 8'h01);
      cap(24'h000100, 24'h000a00);
      cap(24'h000003, 24'h00001e);
      cap(24'h100000, 24'h7fffff);
      cap(24'hf00000, 24'h800000);
      wr(A_CTRL, 8'h05);
      cap(24'h000010, 24'hffff60);
      wr(A_CTRL, 8'h00);
      end_test("capture path");
      for (int i = 0; i < 10; i++) begin
         wr(A_GAIN, g_code[i]);
         settle(2);
         rd_chk(A_GAIN, g_code[i]);
         check({31'h0, mute}, (i > 7) ? 32'h1 : 32'h0);
         if (i < 8) check({24'h0, gain_db}, {24'h0, g_db[i]});
         cap(24'h000100, (i > 7) ? 24'h000000 : 24'h000100);
      end
      end_test("gain table");
      wr(A_GAIN, 8'h00);
      settle(2);
      wr(A_SOFT, 8'hff);
      rd_chk(A_SOFT, 8'h06);
      wr(A_GAIN, 8'h03);
      settle(3);
      check({24'h0, gain_db}, 32'h0);
      step();
      check({24'h0, gain_db}, 32'h1);
      step();
      step();
      step();
      check({24'h0, gain_db}, 32'h3);
      end_test("soft ramp");
      apb(1'b0, A_NONE, 8'h00, r, e);
      check({r[30:0], e}, 32'h1);
      apb(1'b1, A_NONE, 8'hff, r, e);
      check({31'h0, e}, 32'h1);
      rd_chk(A_GAIN, 8'h03);
      end_test("unmapped address");
      test_done();
   end
endmodule : hbc_regs_top_tb
`default_nettype wire
